// File: shared/ied_pkg.sv
package ied_pkg;
	// Operation codes; unused codes write nothing so a decoder slip is seen
	typedef enum logic [4:0] {
		IED_OP_MOVE = 5'h00,
		IED_OP_MOVE_SX = 5'h01,
		IED_OP_MOVE_ZX = 5'h02,
		IED_OP_MOVE_PAIR = 5'h03,
		IED_OP_ADD = 5'h04,
		IED_OP_ADD_CARRY = 5'h05,
		IED_OP_ADD_PAIR = 5'h06,
		IED_OP_MAC_FRAC = 5'h07,
		IED_OP_MAC_SIGNED = 5'h08,
		IED_OP_MAC_UNSIGNED = 5'h09,
		IED_OP_MUL_SAME = 5'h0a,
		IED_OP_MUL_WIDEN_BYTE = 5'h0b,
		IED_OP_MUL_WIDEN_WORD_S = 5'h0c,
		IED_OP_MUL_WIDEN_WORD_U = 5'h0d,
		IED_OP_SUB = 5'h0e,
		IED_OP_SUB_PAIR = 5'h0f,
		IED_OP_SUB_BORROW = 5'h10,
		IED_OP_CMP = 5'h11,
		IED_OP_CMP_PAIR = 5'h12,
		IED_OP_BR_ZERO = 5'h13,
		IED_OP_BR_NONZERO = 5'h14,
		IED_OP_AND = 5'h15,
		IED_OP_AND_PAIR = 5'h16,
		IED_OP_OR = 5'h17,
		IED_OP_OR_PAIR = 5'h18,
		IED_OP_XOR = 5'h19,
		IED_OP_XOR_PAIR = 5'h1a,
		IED_OP_SAVE_COND = 5'h1b
	} ied_op_e;

	// Condition selector
	typedef enum logic [3:0] {
		IED_CC_EQ = 4'h0,
		IED_CC_NE = 4'h1,
		IED_CC_CS = 4'h2,
		IED_CC_CC = 4'h3,
		IED_CC_LO = 4'h4,
		IED_CC_HS = 4'h5,
		IED_CC_LT = 4'h6,
		IED_CC_GE = 4'h7,
		IED_CC_FS = 4'h8,
		IED_CC_FC = 4'h9,
		IED_CC_AL = 4'ha
	} ied_cc_e;

	typedef enum logic [1:0] {
		IED_ST_IDLE = 2'b01,
		IED_ST_DONE = 2'b10
	} ied_state_e;

	localparam int IED_WORD_W = 16;
	localparam int IED_PAIR_W = 32;
	localparam int IED_DISP_W = 24;
	localparam int IED_BYTE_SIGN = 7;
	localparam int IED_WORD_SIGN = 15;
	localparam logic [4:0] IED_FLAG_RESET = 5'h00;
	localparam int IED_FLAG_C = 0;
	localparam int IED_FLAG_Z = 1;
	localparam int IED_FLAG_N = 2;
	localparam int IED_FLAG_L = 3;
	localparam int IED_FLAG_F = 4;

	// One issued operation
	typedef struct packed {
		ied_op_e op;
		logic word;
		logic use_imm;
		ied_cc_e cond;
		logic [IED_PAIR_W-1:0] imm;
		logic [IED_DISP_W-1:0] disp;
		logic [IED_WORD_W-1:0] src_lo;
		logic [IED_WORD_W-1:0] src_hi;
		logic [IED_WORD_W-1:0] src2;
		logic [IED_WORD_W-1:0] dst_lo;
		logic [IED_WORD_W-1:0] dst_hi;
	} ied_req_s;

	// One registered result
	typedef struct packed {
		logic wr_lo;
		logic wr_hi;
		logic [IED_WORD_W-1:0] res_lo;
		logic [IED_WORD_W-1:0] res_hi;
		logic br_taken;
		logic [IED_DISP_W-1:0] br_disp;
	} ied_rsp_s;
endpackage : ied_pkg

// File: logic/ied_mul.sv
`timescale 1ns/1ps
module ied_mul (
	// Operands
	input wire logic [ied_pkg::IED_WORD_W-1:0] a,
	input wire logic [ied_pkg::IED_WORD_W-1:0] b,
	input wire logic is_signed,
	// Product
	output logic [ied_pkg::IED_PAIR_W-1:0] prod
);
	import ied_pkg::*;
	logic signed [IED_WORD_W:0] a_x;
	logic signed [IED_WORD_W:0] b_x;
	logic signed [2*IED_WORD_W+1:0] p_x;
	// One 17x17 signed array serves both signed and unsigned forms
	always_comb begin
		a_x = {is_signed & a[IED_WORD_W-1], a};
		b_x = {is_signed & b[IED_WORD_W-1], b};
		p_x = a_x * b_x;
		prod = p_x[IED_PAIR_W-1:0];
	end
endmodule : ied_mul

// File: logic/ied_cond.sv
`timescale 1ns/1ps
module ied_cond (
	// Flags and selector
	input wire logic [4:0] flags,
	input wire ied_pkg::ied_cc_e cond,
	// Result
	output logic hit
);
	import ied_pkg::*;
	always_comb begin
		case (cond)
			IED_CC_EQ: hit = flags[IED_FLAG_Z];
			IED_CC_NE: hit = ~flags[IED_FLAG_Z];
			IED_CC_CS: hit = flags[IED_FLAG_C];
			IED_CC_CC: hit = ~flags[IED_FLAG_C];
			IED_CC_LO: hit = flags[IED_FLAG_L];
			IED_CC_HS: hit = ~flags[IED_FLAG_L];
			IED_CC_LT: hit = flags[IED_FLAG_N];
			IED_CC_GE: hit = ~flags[IED_FLAG_N];
			IED_CC_FS: hit = flags[IED_FLAG_F];
			IED_CC_FC: hit = ~flags[IED_FLAG_F];
			IED_CC_AL: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end
endmodule : ied_cond

// File: logic/ied_execute.sv
`timescale 1ns/1ps
// Function
// RULE_01: sized operations come in byte (8-bit) and word (16-bit) forms.
// RULE_02: conditional operations take a selector with at least equal, not equal.
// RULE_03: immediate and displacement fields accepted at their full widths.
// RULE_04: pair move loads 32 bits from immediate or another pair.
// RULE_05: sign-extending moves fill upper bits with source sign bit.
// RULE_06: zero-extending moves fill upper bits with zero.
// RULE_07: pair add writes 32-bit sum of pair or immediate into pair.
// RULE_08: signed/unsigned MAC adds 16x16 product to destination pair.
// RULE_09: same-size multiply keeps 8-bit or 16-bit result.
// RULE_10: byte-widening multiply writes 16-bit signed product.
// RULE_11: word-widening multiplies write 32-bit product, signed or unsigned.
// RULE_12: single subtract stores destination minus source or immediate.
// RULE_13: pair subtract stores 32-bit difference into pair.
// RULE_14: subtract with borrow includes stored carry for chaining.
// RULE_15: compares compute difference for flags, leave destination unchanged.
// RULE_16: zero-compare branches take displacement on zero or nonzero.
// RULE_17: AND forms write bitwise AND, single or pair.
// RULE_18: OR forms write bitwise OR, single or pair.
// RULE_19: XOR forms write bitwise XOR, single or pair.
// RULE_20: save-condition writes selected condition as boolean.
// RULE_21: pair low half in lower register, high half in higher.
// RULE_22: fractional MAC doubles signed product before accumulating.
// RULE_23: add with carry adds source and stored carry to destination.
module ied_execute (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Issue
	input wire logic req_valid,
	input wire ied_pkg::ied_req_s req,
	output logic req_ready,
	// Result
	output logic rsp_valid,
	output ied_pkg::ied_rsp_s rsp,
	// Condition flags
	output logic [4:0] flags
);
	import ied_pkg::*;

	ied_state_e state_r, state_nxt;
	ied_rsp_s rsp_r, rsp_nxt;
	logic [4:0] flags_r, flags_nxt;
	logic [IED_WORD_W-1:0] op_b;
	logic [IED_PAIR_W-1:0] dst_p, src_p;
	logic [IED_PAIR_W-1:0] prod;
	logic [IED_PAIR_W:0] sum_p;
	logic [IED_WORD_W:0] sum_w;
	logic [IED_WORD_W-1:0] mul_a, mul_b;
	logic mul_signed;
	logic cond_hit;
	logic carry_in;
	logic [IED_WORD_W-1:0] lo, hi;
	logic wlo, whi, btk, setf, pairf, sub_op;

	ied_mul ied_mul_inst (
		.a(mul_a),
		.b(mul_b),
		.is_signed(mul_signed),
		.prod(prod)
	);

	ied_cond ied_cond_inst (
		.flags(flags_r),
		.cond(req.cond),
		.hit(cond_hit)
	);

	// Always ready: every operation completes in one cycle
	assign req_ready = 1'b1;
	assign rsp_valid = (state_r == IED_ST_DONE);
	assign rsp = rsp_r;
	assign flags = flags_r;

	always_comb begin
		op_b = req.use_imm ? req.imm[IED_WORD_W-1:0] : req.src_lo; // RULE_03
		dst_p = {req.dst_hi, req.dst_lo}; // RULE_21
		src_p = req.use_imm ? req.imm : {req.src_hi, req.src_lo}; // RULE_21
		carry_in = flags_r[IED_FLAG_C];
		mul_a = req.dst_lo;
		mul_b = req.src_lo;
		mul_signed = 1'b1;
		case (req.op)
			IED_OP_MAC_FRAC, IED_OP_MAC_SIGNED, IED_OP_MAC_UNSIGNED: begin
				mul_a = req.src_lo;
				mul_b = req.src2;
				mul_signed = (req.op != IED_OP_MAC_UNSIGNED); // RULE_08
			end
			IED_OP_MUL_WIDEN_BYTE: begin
				mul_a = {{8{req.dst_lo[IED_BYTE_SIGN]}}, req.dst_lo[7:0]};
				mul_b = {{8{req.src_lo[IED_BYTE_SIGN]}}, req.src_lo[7:0]};
			end
			IED_OP_MUL_WIDEN_WORD_U: mul_signed = 1'b0; // RULE_11
			IED_OP_MUL_SAME: mul_b = op_b;
			default: mul_signed = 1'b1;
		endcase
		sub_op = (req.op == IED_OP_SUB) || (req.op == IED_OP_SUB_BORROW) ||
			(req.op == IED_OP_CMP);
		// Shared word adder; subtraction by inverted operand plus one, or plus inverted C for subtract with borrow
		if (sub_op) begin
			sum_w = {1'b0, req.dst_lo} + {1'b0, ~op_b} +
				{16'h0000, (req.op == IED_OP_SUB_BORROW) ? ~carry_in : 1'b1};
		end else begin
			sum_w = {1'b0, req.dst_lo} + {1'b0, op_b} +
				{16'h0000, (req.op == IED_OP_ADD_CARRY) & carry_in}; // RULE_23
		end
		if (req.op == IED_OP_SUB_PAIR || req.op == IED_OP_CMP_PAIR) begin
			sum_p = {1'b0, dst_p} + {1'b0, ~src_p} + 33'h0_0000_0001; // RULE_13
		end else begin
			sum_p = {1'b0, dst_p} + {1'b0, src_p}; // RULE_07
		end
		lo = req.dst_lo;
		hi = req.dst_hi;
		wlo = 1'b1;
		whi = 1'b0;
		btk = 1'b0;
		setf = 1'b0;
		pairf = 1'b0;
		case (req.op)
			IED_OP_MOVE: lo = op_b;
			IED_OP_MOVE_SX: begin
				if (req.word) begin
					lo = req.src_lo;
					hi = {16{req.src_lo[IED_WORD_SIGN]}}; // RULE_05
					whi = 1'b1;
				end else begin
					lo = {{8{req.src_lo[IED_BYTE_SIGN]}}, req.src_lo[7:0]}; // RULE_05
				end
			end
			IED_OP_MOVE_ZX: begin
				if (req.word) begin
					lo = req.src_lo;
					hi = 16'h0000; // RULE_06
					whi = 1'b1;
				end else begin
					lo = {8'h00, req.src_lo[7:0]}; // RULE_06
				end
			end
			IED_OP_MOVE_PAIR: begin
				{hi, lo} = src_p; // RULE_04
				whi = 1'b1;
			end
			IED_OP_ADD, IED_OP_ADD_CARRY, IED_OP_SUB, IED_OP_SUB_BORROW: begin
				lo = sum_w[IED_WORD_W-1:0]; // RULE_12 RULE_14
				setf = 1'b1;
			end
			IED_OP_ADD_PAIR, IED_OP_SUB_PAIR: begin
				{hi, lo} = sum_p[IED_PAIR_W-1:0]; // RULE_07 RULE_13
				whi = 1'b1;
				setf = 1'b1;
				pairf = 1'b1;
			end
			IED_OP_MAC_FRAC: begin
				{hi, lo} = dst_p + {prod[IED_PAIR_W-2:0], 1'b0}; // RULE_22
				whi = 1'b1;
			end
			IED_OP_MAC_SIGNED, IED_OP_MAC_UNSIGNED: begin
				{hi, lo} = dst_p + prod; // RULE_08
				whi = 1'b1;
			end
			IED_OP_MUL_SAME: lo = prod[IED_WORD_W-1:0]; // RULE_09
			IED_OP_MUL_WIDEN_BYTE: lo = prod[IED_WORD_W-1:0]; // RULE_10
			IED_OP_MUL_WIDEN_WORD_S, IED_OP_MUL_WIDEN_WORD_U: begin
				{hi, lo} = prod; // RULE_11
				whi = 1'b1;
			end
			IED_OP_CMP: begin
				wlo = 1'b0; // RULE_15
				setf = 1'b1;
			end
			IED_OP_CMP_PAIR: begin
				wlo = 1'b0; // RULE_15
				setf = 1'b1;
				pairf = 1'b1;
			end
			IED_OP_BR_ZERO, IED_OP_BR_NONZERO: begin
				wlo = 1'b0;
				if (req.word) begin
					btk = (req.src_lo == 16'h0000);
				end else begin
					btk = (req.src_lo[7:0] == 8'h00);
				end
				btk = btk ^ (req.op == IED_OP_BR_NONZERO); // RULE_16
			end
			IED_OP_AND: lo = req.dst_lo & op_b; // RULE_17
			IED_OP_OR: lo = req.dst_lo | op_b; // RULE_18
			IED_OP_XOR: lo = req.dst_lo ^ op_b; // RULE_19
			IED_OP_AND_PAIR: begin
				{hi, lo} = dst_p & src_p; // RULE_17
				whi = 1'b1;
			end
			IED_OP_OR_PAIR: begin
				{hi, lo} = dst_p | src_p; // RULE_18
				whi = 1'b1;
			end
			IED_OP_XOR_PAIR: begin
				{hi, lo} = dst_p ^ src_p; // RULE_19
				whi = 1'b1;
			end
			IED_OP_SAVE_COND: lo = {15'h0000, cond_hit}; // RULE_02 RULE_20
			default: wlo = 1'b0;
		endcase
		// Byte form keeps the upper byte of the destination untouched
		if (!req.word && !whi && wlo && req.op != IED_OP_MOVE_SX &&
			req.op != IED_OP_MOVE_ZX && req.op != IED_OP_MUL_WIDEN_BYTE &&
			req.op != IED_OP_SAVE_COND) begin
			lo = {req.dst_lo[15:8], lo[7:0]}; // RULE_01
		end
	end

	always_comb begin
		state_nxt = req_valid ? IED_ST_DONE : IED_ST_IDLE;
		rsp_nxt = rsp_r;
		flags_nxt = flags_r;
		rsp_nxt.wr_lo = 1'b0;
		rsp_nxt.wr_hi = 1'b0;
		rsp_nxt.br_taken = 1'b0;
		if (req_valid) begin
			rsp_nxt.wr_lo = wlo;
			rsp_nxt.wr_hi = whi;
			rsp_nxt.res_lo = lo;
			rsp_nxt.res_hi = hi;
			rsp_nxt.br_taken = btk;
			rsp_nxt.br_disp = req.disp; // RULE_03
			if (setf && sub_op) begin
				// Z and N follow the width of the operation
				flags_nxt[IED_FLAG_Z] = req.word ? (sum_w[15:0] == 16'h0000) :
					(sum_w[7:0] == 8'h00);
				flags_nxt[IED_FLAG_L] = req.word ? (req.dst_lo < op_b) :
					(req.dst_lo[7:0] < op_b[7:0]);
				flags_nxt[IED_FLAG_N] = req.word ?
					($signed(req.dst_lo) < $signed(op_b)) :
					($signed(req.dst_lo[7:0]) < $signed(op_b[7:0]));
				if (req.op != IED_OP_CMP) begin
					// Byte borrow taken from the adder so the stored borrow counts
					flags_nxt[IED_FLAG_C] = req.word ? ~sum_w[16] :
						~(sum_w[8] ^ req.dst_lo[8] ^ ~op_b[8]); // RULE_14
				end
			end else if (setf && pairf) begin
				flags_nxt[IED_FLAG_Z] = (sum_p[31:0] == 32'h0000_0000);
				if (req.op == IED_OP_CMP_PAIR) begin
					flags_nxt[IED_FLAG_L] = dst_p < src_p;
					flags_nxt[IED_FLAG_N] = $signed(dst_p) < $signed(src_p);
				end
			end else if (setf) begin
				flags_nxt[IED_FLAG_C] = req.word ? sum_w[16] :
					(({1'b0, req.dst_lo[7:0]} + {1'b0, op_b[7:0]} +
					{8'h00, (req.op == IED_OP_ADD_CARRY) & carry_in}) > 9'h0ff);
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= IED_ST_IDLE;
			rsp_r <= '0;
			flags_r <= IED_FLAG_RESET;
		end else begin
			state_r <= state_nxt;
			rsp_r <= rsp_nxt;
			flags_r <= flags_nxt;
		end
	end

	property p_cmp_no_write;
		@(posedge core_clk) disable iff (!rst_b)
		req_valid && (req.op == IED_OP_CMP || req.op == IED_OP_CMP_PAIR)
		|=> rsp_valid && !rsp.wr_lo && !rsp.wr_hi;
	endproperty
	a_cmp_no_write: assert property (p_cmp_no_write) // RULE_15
		else $error("compare wrote its destination");

	property p_zero_extend;
		@(posedge core_clk) disable iff (!rst_b)
		req_valid && req.op == IED_OP_MOVE_ZX && req.word
		|=> rsp.res_hi == 16'h0000 && rsp.wr_hi;
	endproperty
	a_zero_extend: assert property (p_zero_extend) // RULE_06
		else $error("zero extension upper word not zero");

	property p_sign_extend;
		@(posedge core_clk) disable iff (!rst_b)
		req_valid && req.op == IED_OP_MOVE_SX && !req.word
		|=> rsp.res_lo[15:8] == {8{$past(req.src_lo[7])}};
	endproperty
	a_sign_extend: assert property (p_sign_extend) // RULE_05
		else $error("sign extension byte wrong");

	property p_pair_add;
		@(posedge core_clk) disable iff (!rst_b)
		req_valid && req.op == IED_OP_ADD_PAIR && !req.use_imm
		|=> {rsp.res_hi, rsp.res_lo} ==
			$past({req.dst_hi, req.dst_lo} + {req.src_hi, req.src_lo});
	endproperty
	a_pair_add: assert property (p_pair_add) // RULE_07
		else $error("pair add sum wrong");

	property p_pair_sub;
		@(posedge core_clk) disable iff (!rst_b)
		req_valid && req.op == IED_OP_SUB_PAIR && !req.use_imm
		|=> {rsp.res_hi, rsp.res_lo} ==
			$past({req.dst_hi, req.dst_lo} - {req.src_hi, req.src_lo});
	endproperty
	a_pair_sub: assert property (p_pair_sub) // RULE_13
		else $error("pair subtract wrong");

	property p_branch_zero;
		@(posedge core_clk) disable iff (!rst_b)
		req_valid && req.op == IED_OP_BR_ZERO && req.word &&
		req.src_lo == 16'h0000 |=> rsp.br_taken ##1
			(rsp_valid || !rsp.br_taken);
	endproperty
	a_branch_zero: assert property (p_branch_zero) // RULE_16
		else $error("zero branch not taken for one cycle");

	property p_byte_keep;
		@(posedge core_clk) disable iff (!rst_b)
		req_valid && req.op == IED_OP_AND && !req.word
		|=> rsp.res_lo[15:8] == $past(req.dst_lo[15:8]);
	endproperty
	a_byte_keep: assert property (p_byte_keep) // RULE_01
		else $error("byte form touched upper byte");

	property p_mac_u;
		@(posedge core_clk) disable iff (!rst_b)
		req_valid && req.op == IED_OP_MAC_UNSIGNED
		|=> {rsp.res_hi, rsp.res_lo} == $past({req.dst_hi, req.dst_lo} +
			{16'h0000, req.src_lo} * {16'h0000, req.src2});
	endproperty
	a_mac_u: assert property (p_mac_u) // RULE_08
		else $error("unsigned accumulate wrong");

	property p_save_cond;
		@(posedge core_clk) disable iff (!rst_b)
		req_valid && req.op == IED_OP_SAVE_COND && req.cond == IED_CC_EQ
		|=> rsp.res_lo == {15'h0000, $past(flags_r[IED_FLAG_Z])};
	endproperty
	a_save_cond: assert property (p_save_cond) // RULE_20
		else $error("saved condition wrong");
endmodule : ied_execute

// File: test/cpu_integer_execute_datapath_tb.sv
`timescale 1ns/1ps
module cpu_integer_execute_datapath_tb;
	import ied_pkg::*;
	logic core_clk;
	logic rst_b;
	logic req_valid;
	ied_req_s req;
	logic req_ready;
	logic rsp_valid;
	ied_rsp_s rsp;
	logic [4:0] flags;
	int n_fail;
	int checks;

	ied_execute ied_execute_inst (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.req_valid(req_valid),
		.req(req),
		.req_ready(req_ready),
		.rsp_valid(rsp_valid),
		.rsp(rsp),
		.flags(flags)
	);

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic test_done;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done

	task automatic cmp_w(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_w

	task automatic cmp_b(input string nm, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask : cmp_b

	// Inputs change only at the falling edge; results read at the next falling edge
	task automatic run(input ied_op_e op, input logic w, input logic ui,
		input logic [31:0] imm, input logic [31:0] s, input logic [31:0] d);
		req.op = op;
		req.word = w;
		req.use_imm = ui;
		req.imm = imm;
		req.src_lo = s[15:0];
		req.src_hi = s[31:16];
		req.dst_lo = d[15:0];
		req.dst_hi = d[31:16];
		req_valid = 1'b1;
		@(negedge core_clk);
		cmp_b("rsp_valid", 1'b1, rsp_valid);
		cmp_b("req_ready", 1'b1, req_ready);
	endtask : run

	task automatic idle;
		req_valid = 1'b0;
		@(negedge core_clk);
		cmp_b("rsp_valid", 1'b0, rsp_valid);
	endtask : idle

	task automatic exp_lo(input logic [15:0] e);
		cmp_w("res_lo", {16'h0000, e}, {16'h0000, rsp.res_lo});
		cmp_b("wr_lo", 1'b1, rsp.wr_lo);
	endtask : exp_lo

	task automatic exp_pr(input logic [31:0] e);
		cmp_w("res_pair", e, {rsp.res_hi, rsp.res_lo});
		cmp_b("wr_lo", 1'b1, rsp.wr_lo);
		cmp_b("wr_hi", 1'b1, rsp.wr_hi);
	endtask : exp_pr

	task automatic no_wr;
		cmp_b("wr_lo", 1'b0, rsp.wr_lo);
		cmp_b("wr_hi", 1'b0, rsp.wr_hi);
	endtask : no_wr

	task automatic t_move;
		run(IED_OP_MOVE, 1'b0, 1'b0, 0, 32'h0000_0012, 32'h0000_ab00);
		exp_lo(16'hab12);
		run(IED_OP_MOVE, 1'b1, 1'b1, 32'h0000_beef, 0, 0);
		exp_lo(16'hbeef);
		run(IED_OP_MOVE_SX, 1'b0, 1'b0, 0, 32'h0000_ab80, 0);
		exp_lo(16'hff80);
		run(IED_OP_MOVE_SX, 1'b1, 1'b0, 0, 32'h0000_8001, 0);
		exp_pr(32'hffff_8001);
		run(IED_OP_MOVE_ZX, 1'b0, 1'b0, 0, 32'h0000_ab80, 0);
		exp_lo(16'h0080);
		run(IED_OP_MOVE_ZX, 1'b1, 1'b0, 0, 32'h0000_8001, 32'hffff_ffff);
		exp_pr(32'h0000_8001);
		run(IED_OP_MOVE_PAIR, 1'b1, 1'b1, 32'h1234_5678, 0, 0);
		exp_pr(32'h1234_5678);
		run(IED_OP_MOVE_PAIR, 1'b1, 1'b0, 0, 32'h9abc_def0, 0);
		exp_pr(32'h9abc_def0);
		idle();
	endtask : t_move

	// Carry chains run back to back: the second op must see the first's C
	task automatic t_arith;
		run(IED_OP_ADD_PAIR, 1'b1, 1'b0, 0, 32'h0000_0001, 32'h0001_ffff);
		exp_pr(32'h0002_0000);
		run(IED_OP_ADD_PAIR, 1'b1, 1'b1, 32'h0000_8000, 0, 32'h7fff_8000);
		exp_pr(32'h8000_0000);
		run(IED_OP_ADD, 1'b1, 1'b0, 0, 32'h0000_0001, 32'h0000_ffff);
		exp_lo(16'h0000);
		cmp_b("flag_c", 1'b1, flags[IED_FLAG_C]);
		run(IED_OP_ADD_CARRY, 1'b1, 1'b0, 0, 32'h0000_0001, 32'h0000_0001);
		exp_lo(16'h0003);
		run(IED_OP_SUB, 1'b1, 1'b0, 0, 32'h0000_0007, 32'h0000_0005);
		exp_lo(16'hfffe);
		cmp_b("flag_c", 1'b1, flags[IED_FLAG_C]);
		run(IED_OP_SUB_BORROW, 1'b1, 1'b1, 32'h0000_0001, 0, 32'h0000_0010);
		exp_lo(16'h000e);
		run(IED_OP_SUB_PAIR, 1'b1, 1'b1, 32'h0000_0001, 0, 32'h0001_0000);
		exp_pr(32'h0000_ffff);
		run(IED_OP_SUB, 1'b0, 1'b0, 0, 32'h0000_0001, 32'h0000_1200);
		exp_lo(16'h12ff);
		run(IED_OP_SUB_BORROW, 1'b0, 1'b1, 0, 0, 0);
		exp_lo(16'h00ff);
		cmp_b("flag_c", 1'b1, flags[IED_FLAG_C]);
		idle();
	endtask : t_arith

	task automatic t_mul;
		run(IED_OP_MUL_SAME, 1'b0, 1'b0, 0, 32'h0000_0003, 32'h0000_1210);
		exp_lo(16'h1230);
		run(IED_OP_MUL_SAME, 1'b1, 1'b1, 32'h0000_0004, 0, 32'h0000_0123);
		exp_lo(16'h048c);
		run(IED_OP_MUL_WIDEN_BYTE, 1'b0, 1'b0, 0, 32'h0000_0003,
			32'h0000_55fe);
		exp_lo(16'hfffa);
		run(IED_OP_MUL_WIDEN_WORD_S, 1'b1, 1'b0, 0, 32'h0000_0002,
			32'h1234_ffff);
		exp_pr(32'hffff_fffe);
		run(IED_OP_MUL_WIDEN_WORD_U, 1'b1, 1'b0, 0, 32'h0000_0002,
			32'h1234_ffff);
		exp_pr(32'h0001_fffe);
		req.src2 = 16'h0002;
		run(IED_OP_MAC_SIGNED, 1'b1, 1'b0, 0, 32'h0000_ffff, 32'h0000_0010);
		exp_pr(32'h0000_000e);
		run(IED_OP_MAC_UNSIGNED, 1'b1, 1'b0, 0, 32'h0000_ffff,
			32'h0000_0010);
		exp_pr(32'h0002_000e);
		req.src2 = 16'h4000;
		run(IED_OP_MAC_FRAC, 1'b1, 1'b0, 0, 32'h0000_4000, 32'h0000_0001);
		exp_pr(32'h2000_0001);
		idle();
	endtask : t_mul

	task automatic t_cmp;
		ied_cc_e ccs[9] = '{IED_CC_CS, IED_CC_CC, IED_CC_LO, IED_CC_HS,
			IED_CC_LT, IED_CC_GE, IED_CC_FS, IED_CC_FC, IED_CC_AL};
		logic ce[9] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
		run(IED_OP_CMP, 1'b1, 1'b0, 0, 32'h0000_0005, 32'h0000_0005);
		no_wr();
		cmp_b("flag_z", 1'b1, flags[IED_FLAG_Z]);
		req.cond = IED_CC_EQ;
		run(IED_OP_SAVE_COND, 1'b1, 1'b0, 0, 0, 32'h0000_5555);
		exp_lo(16'h0001);
		req.cond = IED_CC_NE;
		run(IED_OP_SAVE_COND, 1'b1, 1'b0, 0, 0, 32'h0000_5555);
		exp_lo(16'h0000);
		run(IED_OP_CMP_PAIR, 1'b1, 1'b1, 32'h1234_5678, 0, 32'h1234_5678);
		no_wr();
		cmp_b("flag_z", 1'b1, flags[IED_FLAG_Z]);
		run(IED_OP_CMP_PAIR, 1'b1, 1'b1, 32'h0001_0000, 0, 32'h0000_0001);
		cmp_b("flag_z", 1'b0, flags[IED_FLAG_Z]);
		cmp_b("flag_n", 1'b1, flags[IED_FLAG_N]);
		cmp_b("flag_l", 1'b1, flags[IED_FLAG_L]);
		// Flags now C=1 Z=0 N=1 L=1 F=0; every selector but EQ and NE is read back
		for (int i = 0; i < 9; i++) begin
			req.cond = ccs[i];
			run(IED_OP_SAVE_COND, 1'b1, 1'b0, 0, 0, 0);
			exp_lo({15'h0000, ce[i]});
		end
		idle();
	endtask : t_cmp

	task automatic t_branch;
		req.disp = 24'hab_cdef;
		run(IED_OP_BR_ZERO, 1'b1, 1'b0, 0, 0, 0);
		cmp_b("br_taken", 1'b1, rsp.br_taken);
		cmp_w("br_disp", 32'h00ab_cdef, {8'h00, rsp.br_disp});
		run(IED_OP_BR_NONZERO, 1'b1, 1'b0, 0, 0, 0);
		cmp_b("br_taken", 1'b0, rsp.br_taken);
		run(IED_OP_BR_NONZERO, 1'b1, 1'b0, 0, 32'h0000_0100, 0);
		cmp_b("br_taken", 1'b1, rsp.br_taken);
		// Byte form looks at the low byte only
		run(IED_OP_BR_ZERO, 1'b0, 1'b0, 0, 32'h0000_1200, 0);
		cmp_b("br_taken", 1'b1, rsp.br_taken);
		idle();
	endtask : t_branch

	task automatic t_logic;
		ied_op_e ops[3] = '{IED_OP_AND, IED_OP_OR, IED_OP_XOR};
		ied_op_e pops[3] = '{IED_OP_AND_PAIR, IED_OP_OR_PAIR, IED_OP_XOR_PAIR};
		logic [31:0] e[3] = '{32'hf000_0c30, 32'hfff0_3ffc, 32'h0ff0_33cc};
		logic [15:0] eb[3] = '{16'h0f30, 16'h0ffc, 16'h0fcc};
		logic [31:0] d = 32'hf0f0_0ff0;
		logic [31:0] s = 32'hff00_3c3c;
		for (int i = 0; i < 3; i++) begin
			run(ops[i], 1'b1, 1'b1, {16'h0000, s[15:0]}, 0, d);
			exp_lo(e[i][15:0]);
			run(ops[i], 1'b0, 1'b0, 0, s, d);
			exp_lo(eb[i]);
			run(pops[i], 1'b1, 1'b0, 0, s, d);
			exp_pr(e[i]);
		end
		// Illegal code must not write a register
		run(ied_op_e'(5'h1f), 1'b1, 1'b0, 0, s, d);
		no_wr();
		idle();
	endtask : t_logic

	// Slack of about thirty times the expected run length
	initial begin
		#(2000 * 100);
		n_fail++;
		test_done();
	end

	initial begin
		n_fail = 0;
		checks = 0;
		rst_b = 1'b0;
		req_valid = 1'b0;
		req = '0;
		repeat (3) @(negedge core_clk);
		cmp_b("rsp_valid", 1'b0, rsp_valid);
		cmp_w("flags", 32'h0000_0000, {27'h0, flags});
		cmp_w("rsp_lo", 32'h0000_0000, {16'h0000, rsp.res_lo});
		@(negedge core_clk);
		rst_b = 1'b1;
		@(negedge core_clk);
		t_move();
		t_arith();
		t_mul();
		t_cmp();
		t_branch();
		t_logic();
		test_done();
	end
endmodule : cpu_integer_execute_datapath_tb
